// *** include/ppa_pkg.sv ***
package ppa_pkg;

  // ****************************************************
  // register byte offsets on the register bus
  // ****************************************************
  localparam logic [7:0] ADDR_SEL_OFF  = 8'h00; // port_address_and_select
  localparam logic [7:0] PIN_EN_OFF    = 8'h04; // port_pin_enables
  localparam logic [7:0] BUF_STAT_OFF  = 8'h08; // port_buffer_status
  localparam logic [7:0] PAD_CFG_OFF   = 8'h0C; // pad_configuration
  localparam logic [7:0] CTRL_OFF      = 8'h10; // select / step / slave mode
  localparam logic [7:0] OUT_ONE_OFF   = 8'h20; // output_word_one
  localparam logic [7:0] OUT_TWO_OFF   = 8'h24; // output_word_two
  localparam logic [7:0] IN_ONE_OFF    = 8'h28; // input_word_one
  localparam logic [7:0] IN_TWO_OFF    = 8'h2C; // input_word_two
  localparam logic [7:0] IRQ_STAT_OFF  = 8'h30; // sticky events, read clears
  localparam logic [7:0] IRQ_MASK_OFF  = 8'h34; // event mask

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int SEL_TWO_BIT   = 15; // select_two_active
  localparam int SEL_ONE_BIT   = 14; // select_one_active
  localparam int ADDR_W        = 14; // destination address field
  localparam int ST_IN_FULL    = 15; // all_inputs_full
  localparam int ST_IN_OVF     = 14; // input_overflow
  localparam int ST_OUT_EMPTY  = 7;  // all_outputs_empty
  localparam int ST_OUT_UNF    = 6;  // output_underflow
  localparam int PAD_W         = 2;  // pad configuration width
  localparam int CTRL_W        = 5;  // control register width
  localparam int EV_W          = 4;  // interrupt event count
  localparam int EV_OVF        = 0;  // overflow event
  localparam int EV_UNF        = 1;  // underflow event
  localparam int EV_HOST_WR    = 2;  // host wrote a slot
  localparam int EV_HOST_RD    = 3;  // host read a slot

  // ****************************************************
  // encodings and reset values
  // ****************************************************
  localparam logic [1:0] CSF_TWO_SEL   = 2'h2; // both pins chip selects
  localparam logic [1:0] CSF_SEL_ADDR  = 2'h1; // select two plus addr 14
  localparam logic [1:0] CSF_ADDRS     = 2'h0; // both pins address lines
  localparam logic [1:0] STEP_UP       = 2'h1; // address_step_mode up
  localparam logic [1:0] STEP_DOWN     = 2'h2; // address_step_mode down
  localparam logic [3:0] OUT_EMPTY_RST = 4'hF; // output slots empty
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// *** rtl/ppa_port.sv ***
`timescale 1ns/100ps
module ppa_port (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        host_select,
  input  wire logic        host_write,
  input  wire logic        host_read,
  input  wire logic [1:0]  host_addr,
  input  wire logic [7:0]  host_data_in,
  output logic [7:0]       host_data_out,
  output logic             host_data_oe_n,
  input  wire logic        bus_cycle_done,
  output logic [15:0]      port_address_pins,
  output logic [15:0]      pin_function_enable,
  output logic             chip_select_pin_one,
  output logic             chip_select_pin_two,
  output logic [1:0]       pad_config,
  output logic             irq
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [15:0]                  addr_sel;   // address and selects
    logic [15:0]                  pin_en;     // pin enables
    logic [ppa_pkg::PAD_W-1:0]    pad;        // pad configuration
    logic [ppa_pkg::CTRL_W-1:0]   ctrl;       // csf, step, slave mode
    logic [3:0][7:0]              out_buf;    // bytes for the host
    logic [3:0][7:0]              in_buf;     // bytes from the host
    logic [3:0]                   in_full;    // input_slot_full
    logic [3:0]                   out_empty;  // output_slot_empty
    logic                         in_ovf;     // input_overflow
    logic                         out_unf;    // output_underflow
    logic [ppa_pkg::EV_W-1:0]     ev_stat;    // sticky events
    logic [ppa_pkg::EV_W-1:0]     ev_mask;    // event mask
    logic                         irq;        // interrupt level
    logic                         aw_held;    // write address taken
    logic [7:0]                   aw_addr;    // held write address
    logic                         w_held;     // write data taken
    logic [31:0]                  w_data;     // held write data
    logic [3:0]                   w_strb;     // held byte enables
    logic                         bvalid;     // write response
    logic [1:0]                   bresp;      // write status
    logic                         rvalid;     // read response
    logic [1:0]                   rresp;      // read status
    logic [31:0]                  rdata;      // read data
    logic [7:0]                   h_dout;     // host read data
    logic                         h_oe_n;     // host data drive, low on
    logic [15:0]                  pins;       // address pin values
    logic [15:0]                  pin_fn;     // pin ownership
    logic                         cs_one;     // chip select one
    logic                         cs_two;     // chip select two
  } ppa_state_type;

  ppa_state_type s_q; // registered state
  ppa_state_type s_d; // next state

  // helper terms read by the next-state logic and the checks
  logic [1:0] slot;      // selected byte slot
  logic       h_wr;      // host write this cycle
  logic       h_rd;      // host read this cycle
  logic       wr_go;     // register write happens
  logic       rd_go;     // register read happens
  logic [1:0] select_function_field;       // select_function_field
  logic [1:0] step;      // address_step_mode
  logic [15:0] stat_val; // status register image

  // ****************************************************
  // host side decode
  // ****************************************************
  always_comb begin
    select_function_field  = s_q.ctrl[1:0];
    step = s_q.ctrl[3:2];
    // legacy slave mode has one slot, so the address pins are ignored
    slot = s_q.ctrl[4] ? host_addr : 2'h0;
    h_wr = host_select && host_write;
    h_rd = host_select && host_read;
    wr_go = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    rd_go = s_axi_arvalid && !s_q.rvalid;
    // unimplemented pairs stay zero
    stat_val = {&s_q.in_full, s_q.in_ovf, 2'h0, s_q.in_full,
                &s_q.out_empty, s_q.out_unf, 2'h0,
                s_q.out_empty};
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic [ppa_pkg::EV_W-1:0] ev_set; // events this cycle
    logic [3:0] sw_out_fill;          // slots software filled
    logic [3:0] sw_in_take;           // slots software read
    s_d = s_q;
    ev_set = '0;
    sw_out_fill = 4'h0;
    sw_in_take = 4'h0;

    // axi write channels, accepted in either order
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // register write, once address and data are both held
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = ppa_pkg::RESP_OKAY;
      unique case (s_q.aw_addr)
        ppa_pkg::ADDR_SEL_OFF: begin
          if (s_q.w_strb[0]) s_d.addr_sel[7:0] = s_q.w_data[7:0];
          if (s_q.w_strb[1]) s_d.addr_sel[15:8] = s_q.w_data[15:8];
        end
        ppa_pkg::PIN_EN_OFF: begin
          if (s_q.w_strb[0]) s_d.pin_en[7:0] = s_q.w_data[7:0];
          if (s_q.w_strb[1]) s_d.pin_en[15:8] = s_q.w_data[15:8];
        end
        ppa_pkg::BUF_STAT_OFF: begin
          // only zero clears; a one leaves the flag alone
          if (s_q.w_strb[1] && !s_q.w_data[ppa_pkg::ST_IN_OVF])
            s_d.in_ovf = 1'b0;
          if (s_q.w_strb[0] && !s_q.w_data[ppa_pkg::ST_OUT_UNF])
            s_d.out_unf = 1'b0;
        end
        ppa_pkg::PAD_CFG_OFF: begin
          if (s_q.w_strb[0]) s_d.pad = s_q.w_data[ppa_pkg::PAD_W-1:0];
        end
        ppa_pkg::CTRL_OFF: begin
          if (s_q.w_strb[0]) s_d.ctrl = s_q.w_data[ppa_pkg::CTRL_W-1:0];
        end
        ppa_pkg::OUT_ONE_OFF, ppa_pkg::OUT_TWO_OFF: begin
          // low byte goes to the even slot, high byte to the odd one
          for (int b = 0; b < 2; b++) begin
            if (s_q.w_strb[b]) begin
              sw_out_fill[{s_q.aw_addr[2], b[0]}] = 1'b1;
              s_d.out_buf[{s_q.aw_addr[2], b[0]}] = s_q.w_data[8*b +: 8];
            end
          end
        end
        ppa_pkg::IRQ_MASK_OFF: begin
          if (s_q.w_strb[0]) s_d.ev_mask = s_q.w_data[ppa_pkg::EV_W-1:0];
        end
        default: begin
          // unmapped or read-only offset
          s_d.bresp = ppa_pkg::RESP_SLVERR;
        end
      endcase
    end

    // register read, answered one cycle after the address is taken
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = ppa_pkg::RESP_OKAY;
      s_d.rdata = ppa_pkg::UNMAPPED_VAL;
      unique case (s_axi_araddr)
        ppa_pkg::ADDR_SEL_OFF: s_d.rdata[15:0] = s_q.addr_sel;
        ppa_pkg::PIN_EN_OFF:   s_d.rdata[15:0] = s_q.pin_en;
        ppa_pkg::BUF_STAT_OFF: s_d.rdata[15:0] = stat_val;
        ppa_pkg::PAD_CFG_OFF:  s_d.rdata[ppa_pkg::PAD_W-1:0] = s_q.pad;
        ppa_pkg::CTRL_OFF:     s_d.rdata[ppa_pkg::CTRL_W-1:0] = s_q.ctrl;
        ppa_pkg::OUT_ONE_OFF:  s_d.rdata[15:0] = {s_q.out_buf[1],
                                                  s_q.out_buf[0]};
        ppa_pkg::OUT_TWO_OFF:  s_d.rdata[15:0] = {s_q.out_buf[3],
                                                  s_q.out_buf[2]};
        ppa_pkg::IN_ONE_OFF, ppa_pkg::IN_TWO_OFF: begin
          // reading a word takes both of its bytes
          s_d.rdata[15:0] = {s_q.in_buf[{s_axi_araddr[2], 1'b1}],
                             s_q.in_buf[{s_axi_araddr[2], 1'b0}]};
          sw_in_take[{s_axi_araddr[2], 1'b0}] = 1'b1;
          sw_in_take[{s_axi_araddr[2], 1'b1}] = 1'b1;
        end
        ppa_pkg::IRQ_STAT_OFF: begin
          s_d.rdata[ppa_pkg::EV_W-1:0] = s_q.ev_stat;
          s_d.ev_stat = '0; // read clears, new events re-set below
        end
        ppa_pkg::IRQ_MASK_OFF: s_d.rdata[ppa_pkg::EV_W-1:0] = s_q.ev_mask;
        default: s_d.rresp = ppa_pkg::RESP_SLVERR;
      endcase
    end

    // software side of the slot flags
    s_d.out_empty = s_q.out_empty & ~sw_out_fill;
    s_d.in_full = s_q.in_full & ~sw_in_take;

    // host write into a byte slot; a full slot keeps its old byte
    if (h_wr) begin
      ev_set[ppa_pkg::EV_HOST_WR] = 1'b1;
      if (s_q.in_full[slot]) begin
        s_d.in_ovf = 1'b1;
        ev_set[ppa_pkg::EV_OVF] = 1'b1;
      end else begin
        s_d.in_buf[slot] = host_data_in;
        s_d.in_full[slot] = 1'b1;
      end
    end

    // host read of a byte slot; an empty slot returns its stale byte
    s_d.h_oe_n = !h_rd;
    if (h_rd) begin
      ev_set[ppa_pkg::EV_HOST_RD] = 1'b1;
      s_d.h_dout = s_q.out_buf[slot];
      if (s_q.out_empty[slot]) begin
        s_d.out_unf = 1'b1;
        ev_set[ppa_pkg::EV_UNF] = 1'b1;
      end else begin
        s_d.out_empty[slot] = 1'b1;
      end
    end

    // address stepping per finished bus cycle; top bits untouched
    if (bus_cycle_done) begin
      if (step == ppa_pkg::STEP_UP)
        s_d.addr_sel[ppa_pkg::ADDR_W-1:0] =
          s_d.addr_sel[ppa_pkg::ADDR_W-1:0] + 14'h0001;
      else if (step == ppa_pkg::STEP_DOWN)
        s_d.addr_sel[ppa_pkg::ADDR_W-1:0] =
          s_d.addr_sel[ppa_pkg::ADDR_W-1:0] - 14'h0001;
    end

    // sticky events: a set wins over a read clear in the same cycle
    s_d.ev_stat = s_d.ev_stat | ev_set;
    s_d.irq = |(s_d.ev_stat & s_d.ev_mask);

    // pin drive follows the register on the same edge
    s_d.pins = {s_d.addr_sel[15:14],
                s_d.addr_sel[ppa_pkg::ADDR_W-1:0]};
    s_d.pin_fn = s_d.pin_en;
    // reserved function code drives no selects
    s_d.cs_two = (s_d.ctrl[1:0] == ppa_pkg::CSF_TWO_SEL ||
                  s_d.ctrl[1:0] == ppa_pkg::CSF_SEL_ADDR) &&
                 s_d.pin_en[15] &&
                 s_d.addr_sel[ppa_pkg::SEL_TWO_BIT];
    s_d.cs_one = (s_d.ctrl[1:0] == ppa_pkg::CSF_TWO_SEL) &&
                 s_d.pin_en[14] &&
                 s_d.addr_sel[ppa_pkg::SEL_ONE_BIT];
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.out_empty <= ppa_pkg::OUT_EMPTY_RST;
      s_q.h_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready       = !s_q.aw_held;
  assign s_axi_wready        = !s_q.w_held;
  assign s_axi_bvalid        = s_q.bvalid;
  assign s_axi_bresp         = s_q.bresp;
  assign s_axi_arready       = !s_q.rvalid;
  assign s_axi_rvalid        = s_q.rvalid;
  assign s_axi_rresp         = s_q.rresp;
  assign s_axi_rdata         = s_q.rdata;
  assign host_data_out       = s_q.h_dout;
  assign host_data_oe_n      = s_q.h_oe_n;
  assign port_address_pins   = s_q.pins;
  assign pin_function_enable = s_q.pin_fn;
  assign chip_select_pin_one = s_q.cs_one;
  assign chip_select_pin_two = s_q.cs_two;
  assign pad_config          = s_q.pad;
  assign irq                 = s_q.irq;

  // ****************************************************
  // checks
  // ****************************************************
  in_overflow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    h_wr && s_q.in_full[slot] |=> s_q.in_ovf)
    else $error("overflow not flagged on write to full slot");

  out_underflow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    h_rd && s_q.out_empty[slot] |=> s_q.out_unf && s_q.out_empty[$past(slot)])
    else $error("underflow not flagged on read of empty slot");

  slot_fill_a: assert property (@(posedge aclk) disable iff (!aresetn)
    h_wr && !s_q.in_full[slot] |=> s_q.in_full[$past(slot)] &&
      s_q.in_buf[$past(slot)] == $past(host_data_in))
    else $error("host byte not stored in its slot");

  status_image_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    rd_go && s_axi_araddr == ppa_pkg::BUF_STAT_OFF |=>
      s_q.rdata[15] == &$past(s_q.in_full) &&
      s_q.rdata[7] == &$past(s_q.out_empty) &&
      s_q.rdata[13:12] == 2'h0 && s_q.rdata[5:4] == 2'h0)
    else $error("status read image wrong");

  addr_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bus_cycle_done && !wr_go && step == ppa_pkg::STEP_UP |=>
      s_q.addr_sel[13:0] == $past(s_q.addr_sel[13:0]) + 14'h0001)
    else $error("address did not step up");

  addr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bus_cycle_done && !wr_go && step == 2'h0 |=>
      $stable(s_q.addr_sel))
    else $error("address moved with stepping off");

  // the pins take the written enables on the same edge as the register
  pin_owner_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_go && s_q.aw_addr == ppa_pkg::PIN_EN_OFF && &s_q.w_strb[1:0] |=>
      s_q.pin_fn == $past(s_q.w_data[15:0]))
    else $error("pin ownership does not follow its enables");

  select_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
    select_function_field == ppa_pkg::CSF_ADDRS |-> !s_q.cs_two ##1 1'b1)
    else $error("select two driven in address mode");

  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && s_q.aw_addr == ppa_pkg::BUF_STAT_OFF && s_q.w_strb[1] &&
      s_q.w_data[14] && !s_q.in_ovf && !h_wr |=> !s_q.in_ovf)
    else $error("writing one set the overflow flag");

  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.irq == |(s_q.ev_stat & s_q.ev_mask))
    else $error("interrupt level disagrees with unmasked events");

endmodule

// *** sim/ppa_host.sv ***
`timescale 1ns/100ps
// ****************************************************
// external host on the slave side of the port
// ****************************************************
module ppa_host (
  input  wire logic       aclk,
  output logic            host_select,
  output logic            host_write,
  output logic            host_read,
  output logic [1:0]      host_addr,
  output logic [7:0]      host_data_in,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe_n
);
  // idle: not selected, data line parked on a pattern
  initial begin
    host_select  = 1'b0;
    host_write   = 1'b0;
    host_read    = 1'b0;
    host_addr    = 2'h0;
    host_data_in = 8'h5A;
  end
  // one write strobe cycle to a byte slot
  task automatic wr(input logic [1:0] slot, input logic [7:0] b);
    host_select  <= 1'b1;
    host_write   <= 1'b1;
    host_addr    <= slot;
    host_data_in <= b;
    @(posedge aclk);
    host_select  <= 1'b0;
    host_write   <= 1'b0;
    host_addr    <= ~slot;
    // released lines must not echo the last byte
    host_data_in <= ~b;
  endtask
  // one read strobe cycle; byte and drive flag seen a cycle later
  task automatic rd(input logic [1:0] slot, output logic [7:0] b,
                    output logic oe_n);
    host_select <= 1'b1;
    host_read   <= 1'b1;
    host_addr   <= slot;
    @(posedge aclk);
    host_select <= 1'b0;
    host_read   <= 1'b0;
    host_addr   <= ~slot;
    @(posedge aclk);
    b    = host_data_out;
    oe_n = host_data_oe_n;
  endtask
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  // ****************************************************
  // signals
  // ****************************************************
  logic        aclk = 1'b0;
  logic        aresetn, bus_cycle_done, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, host_data_in, host_data_out;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, host_data_oe_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, host_addr, pad_config;
  logic        host_select, host_write, host_read;
  logic        chip_select_pin_one, chip_select_pin_two;
  logic [15:0] port_address_pins, pin_function_enable;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  always #20 aclk = ~aclk;
  ppa_port u_ppa_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_select, .host_write,
    .host_read, .host_addr, .host_data_in, .host_data_out,
    .host_data_oe_n, .bus_cycle_done, .port_address_pins,
    .pin_function_enable, .chip_select_pin_one, .chip_select_pin_two,
    .pad_config, .irq);
  ppa_host u_ppa_host (.aclk, .host_select, .host_write, .host_read,
    .host_addr, .host_data_in, .host_data_out, .host_data_oe_n);
  // ****************************************************
  // compare, verdict and hang guard
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // ****************************************************
  // register bus master; bready/rready held high throughout
  // ****************************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(32'(r), 32'(ppa_pkg::RESP_OKAY));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, exp);
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  // select roles over every function code, then select bits cleared
  task automatic test_selects();
    logic [1:0]  select_function_field;
    logic [15:0] en;
    logic        exp_two;
    wr(ppa_pkg::ADDR_SEL_OFF, 32'h0000_C123);
    for (int i = 0; i < 5; i++) begin
      select_function_field = (i == 4) ? 2'h2 : i[1:0];
      en  = (i == 4) ? 16'h3FFF : 16'hFFFF;
      wr(ppa_pkg::PIN_EN_OFF, {16'h0, en});
      wr(ppa_pkg::CTRL_OFF, {30'h0, select_function_field});
      @(posedge aclk);
      chk(32'(pin_function_enable), 32'(en));
      chk(32'(port_address_pins), 32'h0000_C123);
      exp_two = en[15] && (select_function_field == 2'h1 || select_function_field == 2'h2);
      chk(32'(chip_select_pin_two), 32'(exp_two));
      chk(32'(chip_select_pin_one), 32'(en[14] && select_function_field == 2'h2));
    end
    wr(ppa_pkg::PIN_EN_OFF, 32'h0000_FFFF);
    wr(ppa_pkg::ADDR_SEL_OFF, 32'h0000_0123);
    @(posedge aclk);
    chk(32'({chip_select_pin_two, chip_select_pin_one}), 32'h0);
  endtask
  // address step: hold, up one, down one
  task automatic test_step();
    logic [31:0] exp;
    exp = 32'h0000_0005;
    wr(ppa_pkg::ADDR_SEL_OFF, exp);
    for (int i = 0; i < 3; i++) begin
      wr(ppa_pkg::CTRL_OFF, {28'h0, i[1:0], 2'h0});
      bus_cycle_done <= 1'b1;
      @(posedge aclk);
      bus_cycle_done <= 1'b0;
      exp = (i == 1) ? exp + 1 : (i == 2) ? exp - 1 : exp;
      rd_chk(ppa_pkg::ADDR_SEL_OFF, exp);
    end
  endtask
  // host fills all input slots, overflows one, software drains
  task automatic test_inputs();
    logic [31:0] exp;
    wr(ppa_pkg::CTRL_OFF, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      u_ppa_host.wr(i[1:0], 8'h10 + 8'(i));
      exp = {16'h0, i == 3, 3'h0, 4'((1 << (i + 1)) - 1), 8'h8F};
      rd_chk(ppa_pkg::BUF_STAT_OFF, exp);
    end
    u_ppa_host.wr(2'h2, 8'hEE);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_CF8F);
    rd_chk(ppa_pkg::IN_ONE_OFF, 32'h0000_1110);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_4C8F);
    wr(ppa_pkg::BUF_STAT_OFF, 32'h0000_0000);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_0C8F);
    wr(ppa_pkg::BUF_STAT_OFF, 32'h0000_4000);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_0C8F);
    rd_chk(ppa_pkg::IN_TWO_OFF, 32'h0000_1312);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_008F);
  endtask
  // software fills output slots, host drains, then over-reads
  task automatic test_outputs();
    logic [7:0] b;
    logic       oe_n;
    wr(ppa_pkg::OUT_ONE_OFF, 32'h0000_B2A1);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_000C);
    wr(ppa_pkg::OUT_TWO_OFF, 32'h0000_D4C3);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      u_ppa_host.rd(i[1:0], b, oe_n);
      chk(32'(b), 32'(32'hD4C3_B2A1 >> (8 * i)) & 32'hFF);
      chk(32'(oe_n), 32'h0);
    end
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_008F);
    u_ppa_host.rd(2'h1, b, oe_n);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_00CF);
    wr(ppa_pkg::BUF_STAT_OFF, 32'h0000_0040);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_00CF);
    wr(ppa_pkg::BUF_STAT_OFF, 32'h0000_0000);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_008F);
  endtask
  // sticky events, mask, read clear, refused accesses
  task automatic test_events();
    logic [31:0] d;
    logic [1:0]  r;
    logic        irq_open;
    wr(ppa_pkg::IRQ_MASK_OFF, 32'h0);
    axi_rd(ppa_pkg::IRQ_STAT_OFF, d, r);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    u_ppa_host.wr(2'h0, 8'h55);
    repeat (3) @(posedge aclk);
    irq_open = irq;
    wr(ppa_pkg::IRQ_MASK_OFF, 32'h0000_000F);
    repeat (2) @(posedge aclk);
    // closed before the mask opens, high after
    chk(32'({irq_open, irq}), 32'h1);
    rd_chk(ppa_pkg::IRQ_STAT_OFF, 32'h0000_0004);
    rd_chk(ppa_pkg::IRQ_STAT_OFF, 32'h0);
    // read clear drops the level
    chk(32'(irq), 32'h0);
    // pad configuration bits reach their pins and read back
    wr(ppa_pkg::PAD_CFG_OFF, 32'h0000_0003);
    chk(32'(pad_config), 32'h3);
    rd_chk(ppa_pkg::PAD_CFG_OFF, 32'h0000_0003);
    axi_rd(8'h3C, d, r);
    chk({d[29:0], r}, 32'(ppa_pkg::RESP_SLVERR));
    axi_wr(ppa_pkg::IN_ONE_OFF, 32'h0, r);
    chk(32'(r), 32'(ppa_pkg::RESP_SLVERR));
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    aresetn        = 1'b0;
    bus_cycle_done = 1'b0;
    s_axi_awaddr   = 8'h0;
    s_axi_araddr   = 8'h0;
    s_axi_wdata    = 32'h0;
    s_axi_wstrb    = 4'hF;
    s_axi_awvalid  = 1'b0;
    s_axi_wvalid   = 1'b0;
    s_axi_arvalid  = 1'b0;
    s_axi_bready   = 1'b1;
    s_axi_rready   = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(ppa_pkg::BUF_STAT_OFF, 32'h0000_008F);
    rd_chk(ppa_pkg::ADDR_SEL_OFF, 32'h0);
    test_selects();
    test_step();
    test_inputs();
    test_outputs();
    test_events();
    complete_run();
  end
endmodule
